//--- module_sideband_control.sv
// Sideband control, status and management bus slave of a cable end
//
// Operation
// RQ1: With select low, the module answers management bus commands.
// RQ2: With select high, no acknowledge and no answer on the bus.
// RQ3: Host drives only one module's select low on a shared bus.
// RQ4: An undriven select reads high through the internal pull-up.
// RQ5: Reset held low past minimum length restores all settings to default.
// RQ6: Host ignores status bits until reset completion is flagged.
// RQ7: After insertion, reset completion is flagged without a reset pulse.
// RQ8: Interrupt is open collector, pulled low on a flagged condition.
// RQ9: Host reads the module over the bus to find the interrupt cause.
// RQ10: Presence output is tied low inside the module.
// RQ11: Low-power input is active high and selects the low-power state.
// RQ12: Reset input synchronised, shorter low pulses than minimum ignored.
// RQ13: Interrupt released once causes are read and none remains.
`timescale 1ns/10ps
`default_nettype none

module module_sideband_control
  import sideband_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Host sideband pins
  input wire logic bus_select_n,
  input wire logic module_reset_n,
  input wire logic low_power_request,
  output logic fault_irq_n,
  output logic fault_irq_n_oe,
  output logic present_n,
  // Two-wire management bus
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Module core
  input wire logic fault_event,
  output logic low_power_state,
  output logic [7:0] user_settings,
  output logic module_in_reset
);

  // ==========================================================
  // Pin synchronisers
  logic [SYNC_W-1:0] pins_s;
  logic sel_n_s;
  logic mrst_n_s;
  logic lp_s;
  logic scl_s;
  logic sda_s;

  // RQ4 idle-high select
  // Select resets high, so an unselected module stays silent
  pin_sync #(
    .WIDTH(SYNC_W),
    .RESET_VAL(SYNC_RESET_VAL)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in({bus_select_n, module_reset_n, low_power_request, scl, sda_i}),
    .pin_sync_out(pins_s)
  );

  assign sel_n_s = pins_s[PIN_SEL];
  assign mrst_n_s = pins_s[PIN_MRST];
  assign lp_s = pins_s[PIN_LP];
  assign scl_s = pins_s[PIN_SCL];
  assign sda_s = pins_s[PIN_SDA];

  // ==========================================================
  // Module reset qualifier
  logic [RST_CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;
  logic in_reset_r, in_reset_nxt;
  logic rst_release;

  always_comb begin
    rst_cnt_nxt = rst_cnt_r;
    in_reset_nxt = in_reset_r;
    // RQ12 pulse width filter
    if (!mrst_n_s) begin
      if (rst_cnt_r != RESET_MIN_CNT) begin
        rst_cnt_nxt = rst_cnt_r + 1'b1;
      end else begin
        in_reset_nxt = 1'b1;
      end
    end else begin
      rst_cnt_nxt = '0;
      in_reset_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_r <= '0;
      in_reset_r <= 1'b0;
    end else begin
      rst_cnt_r <= rst_cnt_nxt;
      in_reset_r <= in_reset_nxt;
    end
  end

  assign rst_release = in_reset_r && !in_reset_nxt;

  // ==========================================================
  // Management bus slave and flags
  function automatic logic [7:0] status_byte(input logic fault,
                                             input logic done,
                                             input logic lp);
    logic [7:0] b;
    b = 8'h00;
    b[STAT_FAULT] = fault;
    b[STAT_DONE] = done;
    b[STAT_LP] = lp;
    return b;
  endfunction : status_byte

  bus_state_t state_r, state_nxt;
  logic scl_d_r, sda_d_r;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic full_r, full_nxt;
  logic rw_r, rw_nxt;
  logic more_r, more_nxt;
  logic sda_oe_r, sda_oe_nxt;
  logic [7:0] settings_r, settings_nxt;
  logic fault_r, fault_nxt;
  logic done_r, done_nxt;
  logic lp_r;
  logic irq_oe_r;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic clr_fault, clr_done;

  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    bit_cnt_nxt = bit_cnt_r;
    full_nxt = full_r;
    rw_nxt = rw_r;
    more_nxt = more_r;
    sda_oe_nxt = sda_oe_r;
    settings_nxt = settings_r;
    clr_fault = 1'b0;
    clr_done = 1'b0;
    if (in_reset_r) begin
      // RQ5 defaults restored
      state_nxt = ST_IDLE;
      sda_oe_nxt = 1'b0;
      settings_nxt = SETTINGS_DEFAULT;
      clr_fault = 1'b1;
      clr_done = 1'b1;
    // RQ2 deselected is silent
    end else if (sel_n_s || stop_c) begin
      state_nxt = ST_IDLE;
      sda_oe_nxt = 1'b0;
    // RQ1 selected module answers
    end else if (start_c) begin
      state_nxt = ST_ADDR;
      bit_cnt_nxt = '0;
      full_nxt = 1'b0;
      sda_oe_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_WR_DATA: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_s};
            bit_cnt_nxt = bit_cnt_r + 1'b1;
            full_nxt = (bit_cnt_r == 3'h7);
          end else if (scl_fall && full_r) begin
            full_nxt = 1'b0;
            if (state_r == ST_WR_DATA) begin
              settings_nxt = shift_r;
              sda_oe_nxt = 1'b1;
              state_nxt = ST_WR_ACK;
            end else if (shift_r[7:1] == DEV_ADDR) begin
              rw_nxt = shift_r[0];
              sda_oe_nxt = 1'b1;
              state_nxt = ST_ADDR_ACK;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_WR_ACK, ST_RD_ACK: begin
          if (scl_rise && state_r == ST_RD_ACK) begin
            more_nxt = !sda_s;
          end else if (scl_fall) begin
            bit_cnt_nxt = '0;
            sda_oe_nxt = 1'b0;
            state_nxt = ST_WR_DATA;
            if ((state_r == ST_ADDR_ACK && rw_r) ||
                (state_r == ST_RD_ACK && more_r)) begin
              // RQ13 reading clears reported flags
              tx_nxt = status_byte(fault_r, done_r, lp_r);
              clr_fault = fault_r;
              clr_done = done_r;
              sda_oe_nxt = !tx_nxt[7];
              state_nxt = ST_RD_DATA;
            end else if (state_r == ST_RD_ACK) begin
              // Master NACK ends the read
              state_nxt = ST_IDLE;
            end
          end
        end
        ST_RD_DATA: begin
          if (scl_rise) begin
            bit_cnt_nxt = bit_cnt_r + 1'b1;
            full_nxt = (bit_cnt_r == 3'h7);
          end else if (scl_fall) begin
            if (full_r) begin
              full_nxt = 1'b0;
              sda_oe_nxt = 1'b0;
              state_nxt = ST_RD_ACK;
            end else begin
              tx_nxt = {tx_r[6:0], 1'b0};
              sda_oe_nxt = !tx_r[6];
            end
          end
        end
        default: begin
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
    // Set wins over clear, so no event is lost while being read
    fault_nxt = (fault_r && !clr_fault) || (fault_event && !in_reset_r);
    // RQ6 completion flagged only once reset ends
    done_nxt = (done_r && !clr_done) || rst_release;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      full_r <= 1'b0;
      rw_r <= 1'b0;
      more_r <= 1'b0;
      sda_oe_r <= 1'b0;
      settings_r <= SETTINGS_DEFAULT;
      fault_r <= 1'b0;
      // RQ7 completion flagged at insertion
      done_r <= 1'b1;
      lp_r <= 1'b0;
      irq_oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      full_r <= full_nxt;
      rw_r <= rw_nxt;
      more_r <= more_nxt;
      sda_oe_r <= sda_oe_nxt;
      settings_r <= settings_nxt;
      fault_r <= fault_nxt;
      done_r <= done_nxt;
      // RQ11 low-power follows request
      lp_r <= lp_s;
      // RQ8 pull low while a flag stands
      irq_oe_r <= fault_nxt || done_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // RQ8 open collector drives only low
  assign fault_irq_n = 1'b0;
  assign fault_irq_n_oe = irq_oe_r;
  // RQ10 presence grounded
  assign present_n = 1'b0;
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_r;
  assign low_power_state = lp_r;
  assign user_settings = settings_r;
  assign module_in_reset = in_reset_r;

endmodule : module_sideband_control

`default_nettype wire

//--- sideband_pkg.sv
// Constants shared by the module sideband control logic
`default_nettype none
package sideband_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ = 250;
  // Shortest low level on the module reset pin that counts as a reset
  localparam int RESET_MIN_NS = 10000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_CNT_W = 12;
  localparam logic [RST_CNT_W-1:0] RESET_MIN_CNT = RST_CNT_W'(RESET_MIN_CYC);

  // ==========================================================
  // Pin synchroniser: bit positions and idle levels
  localparam int SYNC_W = 5;
  localparam int PIN_SEL = 4;
  localparam int PIN_MRST = 3;
  localparam int PIN_LP = 2;
  localparam int PIN_SCL = 1;
  localparam int PIN_SDA = 0;
  localparam logic [SYNC_W-1:0] SYNC_RESET_VAL = 5'h1b;

  // ==========================================================
  // Management bus
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [7:0] SETTINGS_DEFAULT = 8'h00;
  // Status byte fields
  localparam int STAT_FAULT = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_LP = 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_DATA,
    ST_WR_ACK,
    ST_RD_DATA,
    ST_RD_ACK
  } bus_state_t;

endpackage : sideband_pkg
`default_nettype wire

//--- pin_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins in, synchronised levels out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RESET_VAL;
      stable_r <= RESET_VAL;
    end else begin
      meta_r <= pin_in;
      stable_r <= meta_r;
    end
  end

  assign pin_sync_out = stable_r;

endmodule : pin_sync

`default_nettype wire

//--- module_sideband_control_properties.sv
// Port assertions for the sideband control block
`timescale 1ns/10ps
`default_nettype none

module module_sideband_control_properties
  import sideband_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Observed ports
  input wire logic bus_select_n,
  input wire logic module_reset_n,
  input wire logic low_power_request,
  input wire logic fault_irq_n,
  input wire logic fault_irq_n_oe,
  input wire logic present_n,
  input wire logic sda_oe,
  input wire logic fault_event,
  input wire logic low_power_state,
  input wire logic [7:0] user_settings,
  input wire logic module_in_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ==========================================
  // Raw low time of the reset pin, saturating
  logic [11:0] low_r, low_nxt;
  always_comb begin
    low_nxt = module_reset_n ? 12'h000 : low_r + {11'h000, low_r != 12'hfff};
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_r <= 12'h000;
    end else begin
      low_r <= low_nxt;
    end
  end

  // ==========================================
  // Properties
  chk_presence_low: assert property (present_n == 1'b0)
    else $error("presence not low");
  chk_irq_drives_low: assert property (fault_irq_n == 1'b0)
    else $error("interrupt drives high");
  chk_fault_raises_irq: assert property (
    fault_event && !module_in_reset |=> fault_irq_n_oe)
    else $error("fault did not pull interrupt");
  chk_deselect_silent: assert property (
    bus_select_n [*4] |-> !sda_oe)
    else $error("bus driven while deselected");
  chk_low_power_follow: assert property (
    $stable(low_power_request) [*4] |-> low_power_state == low_power_request)
    else $error("low power state wrong");
  chk_short_reset_kept: assert property (
    $rose(module_in_reset) |-> low_r >= RESET_MIN_CNT)
    else $error("reset taken from short pulse");
  chk_long_reset_taken: assert property (
    low_r == RESET_MIN_CNT + 12'h00a |-> module_in_reset)
    else $error("long reset pulse missed");
  chk_reset_defaults: assert property (
    module_in_reset [*2] |->
      user_settings == SETTINGS_DEFAULT && !sda_oe && !fault_irq_n_oe)
    else $error("settings or outputs active in reset");
  chk_done_irq_raise: assert property (
    $fell(module_in_reset) |-> ##[1:2] fault_irq_n_oe)
    else $error("no completion interrupt");
endmodule : module_sideband_control_properties

bind module_sideband_control module_sideband_control_properties chk (
  .clk_sys, .rst_n, .bus_select_n, .module_reset_n, .low_power_request,
  .fault_irq_n, .fault_irq_n_oe, .present_n, .sda_oe, .fault_event,
  .low_power_state, .user_settings, .module_in_reset);
`default_nettype wire

//--- host_bus_model.sv
// Behavioural host master of the two-wire management bus
`timescale 1ns/10ps
`default_nettype none

module host_bus_model (
  // Bus lines; pull-up lives on the board
  output var logic scl,
  output var logic sda_pull,
  input wire logic sda
);
  // Quarter of a 125 ns bus period
  localparam realtime Q = 31.25;
  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic start_cond;
    #Q sda_pull = 1'b0;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b0;
    #Q;
  endtask : stop_cond
  // MSB first; ninth bit released for the slave
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
                         output logic nack);
    for (int i = 8; i >= 0; i--) begin
      #Q sda_pull = (i > 0) ? !tx[i-1] : 1'b0;
      #Q scl = 1'b1;
      #Q if (i > 0) rx[i-1] = sda; else nack = sda;
      #Q scl = 1'b0;
    end
  endtask : byte_io
endmodule : host_bus_model
`default_nettype wire

//--- module_sideband_control_tb.sv
// Self-checking bench for the sideband control block
`timescale 1ns/10ps
`default_nettype none

module module_sideband_control_tb
  import sideband_pkg::*;
  ;
  localparam logic [7:0] RD = {DEV_ADDR, 1'b1};
  localparam logic [7:0] WR = {DEV_ADDR, 1'b0};
  localparam logic [7:0] DONE = 8'h01 << STAT_DONE;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic bus_select_n = 1'b1;
  logic module_reset_n = 1'b1;
  logic low_power_request = 1'b0;
  logic fault_event = 1'b0;
  logic scl, sda_pull, sda, irq_pin, fault_irq_n, fault_irq_n_oe;
  logic present_n, sda_o, sda_oe, low_power_state, module_in_reset;
  logic [7:0] user_settings;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  // Open-drain wires with board pull-ups
  assign sda = !sda_pull && (!sda_oe || sda_o);
  assign irq_pin = fault_irq_n_oe ? fault_irq_n : 1'b1;

  module_sideband_control uut (.clk_sys, .rst_n, .bus_select_n,
    .module_reset_n, .low_power_request, .fault_irq_n, .fault_irq_n_oe,
    .present_n, .scl, .sda_i(sda), .sda_o, .sda_oe, .fault_event,
    .low_power_state, .user_settings, .module_in_reset);
  host_bus_model host (.scl, .sda_pull, .sda);

  // ==========================================
  // Shared tasks
  task automatic stop_test;
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic op(input logic [7:0] a, input logic [7:0] d,
                    input logic ack, input logic [7:0] exp);
    logic [7:0] rx, rd;
    logic nack;
    host.start_cond();
    host.byte_io(a, rx, nack);
    cmp({7'h00, !nack}, {7'h00, ack});
    host.byte_io(d, rd, nack);
    // Only an accepted write byte is acknowledged by the module
    cmp({7'h00, nack}, {7'h00, a[0] || !ack});
    host.stop_cond();
    if (a[0]) cmp(rd, exp);
    step(2);
  endtask : op

  // ==========================================
  // Scenarios
  task automatic t_power_up;
    cmp({7'h00, present_n}, 8'h00);
    cmp({7'h00, irq_pin}, 8'h00);
    bus_select_n = 1'b0;
    step(4);
    op(RD, 8'hff, 1'b1, DONE);
    cmp({7'h00, irq_pin}, 8'h01);
    op(RD, 8'hff, 1'b1, 8'h00);
  endtask : t_power_up
  task automatic t_select;
    op(WR, 8'ha5, 1'b1, 8'h00);
    cmp(user_settings, 8'ha5);
    op(WR, 8'h3c, 1'b1, 8'h00);
    op(8'h42, 8'h11, 1'b0, 8'h00);
    cmp(user_settings, 8'h3c);
    bus_select_n = 1'b1;
    step(4);
    op(WR, 8'h5a, 1'b0, 8'h00);
    op(RD, 8'hff, 1'b0, 8'hff);
    cmp(user_settings, 8'h3c);
    bus_select_n = 1'b0;
    step(4);
  endtask : t_select
  task automatic t_fault_lp;
    fault_event = 1'b1;
    step(1);
    fault_event = 1'b0;
    low_power_request = 1'b1;
    step(5);
    cmp({7'h00, irq_pin}, 8'h00);
    cmp({7'h00, low_power_state}, 8'h01);
    op(RD, 8'hff, 1'b1, (8'h01 << STAT_LP) | (8'h01 << STAT_FAULT));
    cmp({7'h00, irq_pin}, 8'h01);
    low_power_request = 1'b0;
    step(5);
    cmp({7'h00, low_power_state}, 8'h00);
  endtask : t_fault_lp
  task automatic t_reset;
    module_reset_n = 1'b0;
    step(RESET_MIN_CYC - 20);
    module_reset_n = 1'b1;
    step(8);
    cmp({7'h00, module_in_reset}, 8'h00);
    cmp(user_settings, 8'h3c);
    module_reset_n = 1'b0;
    step(RESET_MIN_CYC + 20);
    cmp({7'h00, module_in_reset}, 8'h01);
    cmp(user_settings, SETTINGS_DEFAULT);
    op(WR, 8'h77, 1'b0, 8'h00);
    module_reset_n = 1'b1;
    step(6);
    cmp({7'h00, irq_pin}, 8'h00);
    op(RD, 8'hff, 1'b1, DONE);
  endtask : t_reset
  task automatic t_flag_hold;
    fault_event = 1'b1;
    step(1);
    fault_event = 1'b0;
    fork
      op(RD, 8'hff, 1'b1, 8'h01 << STAT_FAULT);
      begin
        // New event lands after the status byte was loaded
        step(400);
        fault_event = 1'b1;
        step(1);
        fault_event = 1'b0;
      end
    join
    cmp({7'h00, irq_pin}, 8'h00);
    op(RD, 8'hff, 1'b1, 8'h01 << STAT_FAULT);
    cmp({7'h00, irq_pin}, 8'h01);
  endtask : t_flag_hold

  // ==========================================
  // Clock, watchdog and main sequence
  initial begin
    forever #2 clk_sys = !clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    step(8);
    rst_n = 1'b1;
    step(2);
    t_power_up();
    t_select();
    t_fault_lp();
    t_reset();
    t_flag_hold();
    stop_test();
  end
endmodule : module_sideband_control_tb
`default_nettype wire
